// >>> inc/irqmsk_pkg.sv
// Purpose: constants and carrier types for the interrupt mask register block
// Assumes: 8-bit register index, 16-bit register data on the device control interface
// Notes:   offsets are register indices as printed
package irqmsk_pkg;
	localparam logic [7:0]  UV_MASK_OFFSET  = 8'h24;
	localparam logic [7:0]  OC_MASK_OFFSET  = 8'h25;
	localparam logic [7:0]  PIN_MASK_OFFSET = 8'h26;
	localparam logic [15:0] MASK_RESET      = 16'h0000;
	// bit layout of the under-voltage register
	localparam int          UV_LINREG_LSB   = 8;
	localparam int          UV_LINREG_CNT   = 4;
	localparam int          UV_CONV_LSB     = 0;
	localparam int          UV_CONV_CNT     = 6;
	localparam logic [15:0] UV_MASK_USED    = 16'h0F3F;
	// over-current register has a single live bit
	localparam int          OC_LIMIT_BIT    = 15;
	localparam logic [15:0] OC_MASK_USED    = 16'h8000;
	// one bit per pin event, bit position equals the pin number
	localparam int          PIN_EVENT_CNT   = 13;
	localparam logic [15:0] PIN_MASK_USED   = 16'h1FFF;

	typedef struct packed {
		logic        writeEn;
		logic        readEn;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} irqmsk_req_t;

	typedef struct packed {
		logic [UV_LINREG_CNT-1:0] linreg;
		logic [UV_CONV_CNT-1:0]   converter;
		logic                     limitSwitch;
		logic [PIN_EVENT_CNT-1:0] pinEvent;
	} irqmsk_evt_t;
endpackage

// >>> design/irqmsk_regs.sv
// Purpose: three interrupt mask registers and the combined interrupt output
// Assumes: event strobes come from logic on core_clk; reset is the power state machine reset
// Notes:   status latches are held here so masking can gate the combined output
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - a mask bit of 0 lets its event reach the interrupt and a bit of 1 blocks it.
// - every mask bit resets to 0 and returns to 0 whenever the power state machine reset fires.
// - the under-voltage mask at 24h keeps linear regulators four to one in bits 11..8 and converters six to one in bits 5..0.
// - the over-current mask at 25h keeps the limit switch mask in bit 15 and nothing else.
// - the pin event mask at 26h keeps one bit per pin 12..0 at the bit matching the pin number.
module irqmsk_regs (
	input  wire logic                      core_clk,
	input  wire logic                      reset,
	input  wire irqmsk_pkg::irqmsk_req_t   regReq,
	output logic [15:0]                    regRdata,
	input  wire irqmsk_pkg::irqmsk_evt_t   eventIn,
	input  wire irqmsk_pkg::irqmsk_evt_t   statusClear,
	output irqmsk_pkg::irqmsk_evt_t        statusOut,
	output logic                           irqOut
);
	import irqmsk_pkg::*;

	logic [15:0]  uvMask_reg;
	logic [15:0]  uvMask_next;
	logic [15:0]  ocMask_reg;
	logic [15:0]  ocMask_next;
	logic [15:0]  pinMask_reg;
	logic [15:0]  pinMask_next;
	logic [15:0]  rdata_reg;
	logic [15:0]  rdata_next;
	logic [15:0]  rdSelected;
	irqmsk_evt_t  status_reg;
	irqmsk_evt_t  status_next;
	irqmsk_evt_t  maskVec;
	irqmsk_evt_t  pendingVec;
	wire          selUv;
	wire          selOc;
	wire          selPin;
	wire          wrUv;
	wire          wrOc;
	wire          wrPin;
	wire          anyPending;

	function automatic logic hit(input irqmsk_req_t r, input logic [7:0] off);
		hit = r.addr == off;
	endfunction

	assign selUv  = hit(regReq, UV_MASK_OFFSET);
	assign selOc  = hit(regReq, OC_MASK_OFFSET);
	assign selPin = hit(regReq, PIN_MASK_OFFSET);
	assign wrUv   = regReq.writeEn & selUv;
	assign wrOc   = regReq.writeEn & selOc;
	assign wrPin  = regReq.writeEn & selPin;

	// unused bits never store, so they always read zero
	assign uvMask_next  = wrUv ? (regReq.wdata & UV_MASK_USED) : uvMask_reg;
	assign ocMask_next  = wrOc ? (regReq.wdata & OC_MASK_USED) : ocMask_reg;
	assign pinMask_next = wrPin ? (regReq.wdata & PIN_MASK_USED) : pinMask_reg;

	always_ff @(posedge core_clk) begin
		if (reset)
			uvMask_reg <= MASK_RESET;
		else
			uvMask_reg <= uvMask_next;
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			ocMask_reg <= MASK_RESET;
		else
			ocMask_reg <= ocMask_next;
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			pinMask_reg <= MASK_RESET;
		else
			pinMask_reg <= pinMask_next;
	end

	// an unmapped index reads zero rather than aliasing a live register
	assign rdSelected = selUv ? uvMask_reg : selOc ? ocMask_reg : selPin ? pinMask_reg : 16'h0000;
	assign rdata_next = regReq.readEn ? rdSelected : rdata_reg;

	always_ff @(posedge core_clk) begin
		if (reset)
			rdata_reg <= 16'h0000;
		else
			rdata_reg <= rdata_next;
	end
	assign regRdata = rdata_reg;

	// field mapping of masks onto the event vector
	assign maskVec.linreg      = uvMask_reg[UV_LINREG_LSB +: UV_LINREG_CNT];
	assign maskVec.converter   = uvMask_reg[UV_CONV_LSB +: UV_CONV_CNT];
	assign maskVec.limitSwitch = ocMask_reg[OC_LIMIT_BIT];
	assign maskVec.pinEvent    = pinMask_reg[PIN_EVENT_CNT-1:0];

	// set wins over clear so an event in the clear cycle is kept; mask never gates latching
	assign status_next = (status_reg & ~statusClear) | eventIn;

	always_ff @(posedge core_clk) begin
		if (reset)
			status_reg <= '0;
		else
			status_reg <= status_next;
	end
	assign statusOut = status_reg;

	// combinational so unmasking a pending latch shows at once
	assign pendingVec = status_reg & ~maskVec;
	assign anyPending = |pendingVec;
	assign irqOut     = anyPending;

	AST_RESET_CLEARS: assert property (@(posedge core_clk)
		reset |=> uvMask_reg == 16'h0000 && ocMask_reg == 16'h0000 && pinMask_reg == 16'h0000)
		else $error("mask not cleared by reset");
	AST_STATUS_RESET: assert property (@(posedge core_clk)
		reset |=> status_reg == '0 && regRdata == 16'h0000 && !irqOut)
		else $error("status or read data not cleared by reset");

	AST_MASK_BLOCKS: assert property (@(posedge core_clk) disable iff (reset)
		(status_reg & ~{uvMask_reg[11:8], uvMask_reg[5:0], ocMask_reg[15], pinMask_reg[12:0]}) == '0 |-> !irqOut)
		else $error("interrupt raised with all pending events masked");
	AST_UNMASKED_FIRES: assert property (@(posedge core_clk) disable iff (reset)
		status_reg.limitSwitch && !ocMask_reg[15] |-> irqOut)
		else $error("unmasked pending event did not raise interrupt");
	AST_MASKED_QUIET: assert property (@(posedge core_clk) disable iff (reset)
		status_reg == irqmsk_evt_t'(24'h00_2000) && ocMask_reg[15] |-> !irqOut)
		else $error("masked over-current event raised interrupt");
	AST_IRQ_NEEDS_STATUS: assert property (@(posedge core_clk) disable iff (reset)
		irqOut |-> status_reg != '0)
		else $error("interrupt raised with nothing latched");

	AST_UV_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		regReq.writeEn && selUv |=> uvMask_reg == ($past(regReq.wdata) & 16'h0F3F))
		else $error("under-voltage mask write wrong");
	AST_OC_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		regReq.writeEn && selOc |=> ocMask_reg == ($past(regReq.wdata) & 16'h8000))
		else $error("over-current mask write wrong");
	AST_PIN_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		regReq.writeEn && selPin |=> pinMask_reg == ($past(regReq.wdata) & 16'h1FFF))
		else $error("pin mask write wrong");
	AST_UNMAPPED_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		regReq.writeEn && !selUv && !selOc && !selPin |=> $stable(uvMask_reg) && $stable(ocMask_reg) && $stable(pinMask_reg))
		else $error("unmapped write changed a mask");
	AST_NO_WRITE_HOLDS: assert property (@(posedge core_clk) disable iff (reset)
		!regReq.writeEn |=> $stable(uvMask_reg) && $stable(ocMask_reg) && $stable(pinMask_reg))
		else $error("mask changed without a write");

	AST_MASKED_LATCH: assert property (@(posedge core_clk) disable iff (reset)
		eventIn.limitSwitch && ocMask_reg[15] |=> status_reg.limitSwitch)
		else $error("masked event not latched");
	AST_LIMIT_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
		statusClear.limitSwitch && !eventIn.limitSwitch |=> !status_reg.limitSwitch)
		else $error("limit switch status not cleared");
	AST_SET_WINS: assert property (@(posedge core_clk) disable iff (reset)
		eventIn.limitSwitch && statusClear.limitSwitch |=> status_reg.limitSwitch)
		else $error("clear beat a same-cycle event");
	AST_UNMASK_PENDING: assert property (@(posedge core_clk) disable iff (reset)
		status_reg.pinEvent[0] && !statusClear.pinEvent[0] && wrPin && !regReq.wdata[0] |=> irqOut)
		else $error("unmasking pending event did not raise interrupt");

	AST_READ_UV: assert property (@(posedge core_clk) disable iff (reset)
		regReq.readEn && selUv |=> regRdata == $past(uvMask_reg))
		else $error("under-voltage mask read wrong");
	AST_READ_OC: assert property (@(posedge core_clk) disable iff (reset)
		regReq.readEn && selOc |=> regRdata == $past(ocMask_reg))
		else $error("over-current mask read wrong");
	AST_READ_PIN: assert property (@(posedge core_clk) disable iff (reset)
		regReq.readEn && selPin |=> regRdata == $past(pinMask_reg))
		else $error("pin mask read wrong");
	AST_READ_UNMAPPED: assert property (@(posedge core_clk) disable iff (reset)
		regReq.readEn && !selUv && !selOc && !selPin |=> regRdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_RDATA_HOLDS: assert property (@(posedge core_clk) disable iff (reset)
		!regReq.readEn |=> $stable(regRdata))
		else $error("read data changed without a read");

	// per-bit checks keep a swapped field from hiding behind the wide or
	for (genvar g = 0; g < PIN_EVENT_CNT; g++) begin : gPinChecks
		AST_PIN_GATE: assert property (@(posedge core_clk) disable iff (reset)
			status_reg.pinEvent[g] && !pinMask_reg[g] |-> irqOut)
			else $error("unmasked pin event did not raise interrupt");
		AST_PIN_LATCH: assert property (@(posedge core_clk) disable iff (reset)
			eventIn.pinEvent[g] |=> status_reg.pinEvent[g])
			else $error("pin event not latched");
		AST_PIN_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
			statusClear.pinEvent[g] && !eventIn.pinEvent[g] |=> !status_reg.pinEvent[g])
			else $error("pin status not cleared");
		AST_PIN_HOLD: assert property (@(posedge core_clk) disable iff (reset)
			status_reg.pinEvent[g] && !statusClear.pinEvent[g] |=> status_reg.pinEvent[g])
			else $error("pin status lost without a clear");
	end

	for (genvar g = 0; g < UV_LINREG_CNT; g++) begin : gLinregChecks
		AST_LINREG_GATE: assert property (@(posedge core_clk) disable iff (reset)
			status_reg.linreg[g] && !uvMask_reg[UV_LINREG_LSB + g] |-> irqOut)
			else $error("unmasked regulator event did not raise interrupt");
		AST_LINREG_BLOCK: assert property (@(posedge core_clk) disable iff (reset)
			uvMask_reg[UV_LINREG_LSB + g] |-> !pendingVec.linreg[g])
			else $error("masked regulator event still pending");
		AST_LINREG_LATCH: assert property (@(posedge core_clk) disable iff (reset)
			eventIn.linreg[g] |=> status_reg.linreg[g])
			else $error("regulator event not latched");
	end

	for (genvar g = 0; g < UV_CONV_CNT; g++) begin : gConvChecks
		AST_CONV_GATE: assert property (@(posedge core_clk) disable iff (reset)
			status_reg.converter[g] && !uvMask_reg[UV_CONV_LSB + g] |-> irqOut)
			else $error("unmasked converter event did not raise interrupt");
		AST_CONV_BLOCK: assert property (@(posedge core_clk) disable iff (reset)
			uvMask_reg[UV_CONV_LSB + g] |-> !pendingVec.converter[g])
			else $error("masked converter event still pending");
		AST_CONV_LATCH: assert property (@(posedge core_clk) disable iff (reset)
			eventIn.converter[g] |=> status_reg.converter[g])
			else $error("converter event not latched");
	end

	COV_MASKED_EVENT: cover property (@(posedge core_clk) eventIn.converter[0] && maskVec.converter[0] ##1 !irqOut);
	COV_UNMASK: cover property (@(posedge core_clk) status_reg.pinEvent[12] && maskVec.pinEvent[12] ##1 !maskVec.pinEvent[12]);
	COV_IRQ: cover property (@(posedge core_clk) !irqOut ##1 irqOut);
	COV_READ_PIN: cover property (@(posedge core_clk) regReq.readEn && selPin ##1 regRdata != 16'h0000);
	COV_SET_AND_CLEAR: cover property (@(posedge core_clk) eventIn.limitSwitch && statusClear.limitSwitch);
endmodule // irqmsk_regs

`default_nettype wire

// >>> tb/tb_irqmsk_regs.sv
// Purpose: random self-checking bench for the interrupt mask registers
// Assumes: inputs change at the falling edge, model updates at the rising edge
// Notes:   a mid-run reset shows the masks falling back to zero
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
	samples_checked++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); \
	end \
end
module tb_irqmsk_regs;
	import irqmsk_pkg::*;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	irqmsk_req_t regReq = '0;
	irqmsk_evt_t eventIn = '0;
	irqmsk_evt_t statusClear = '0;
	irqmsk_evt_t statusOut;
	logic [15:0] regRdata;
	logic        irqOut;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	logic [15:0] mUv = '0, mOc = '0, mPin = '0, mRd = '0;
	logic [23:0] mSt = '0;
	logic [31:0] lf = 32'h0000_73c8;
	wire  [23:0] mVec = {mUv[11:8], mUv[5:0], mOc[15], mPin[12:0]};

	always #10 core_clk = ~core_clk;

	irqmsk_regs dut (.core_clk(core_clk), .reset(reset), .regReq(regReq), .regRdata(regRdata),
		.eventIn(eventIn), .statusClear(statusClear), .statusOut(statusOut), .irqOut(irqOut));

	function automatic logic [31:0] step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// model: read takes the value before a same-edge write; set beats clear
	always @(posedge core_clk) begin
		if (reset) begin
			mUv = '0;
			mOc = '0;
			mPin = '0;
			mRd = '0;
			mSt = '0;
		end else begin
			if (regReq.readEn)
				mRd = regReq.addr == UV_MASK_OFFSET ? mUv : regReq.addr == OC_MASK_OFFSET ? mOc :
					regReq.addr == PIN_MASK_OFFSET ? mPin : 16'h0000;
			if (regReq.writeEn && regReq.addr == UV_MASK_OFFSET) mUv = regReq.wdata & 16'h0F3F;
			if (regReq.writeEn && regReq.addr == OC_MASK_OFFSET) mOc = regReq.wdata & 16'h8000;
			if (regReq.writeEn && regReq.addr == PIN_MASK_OFFSET) mPin = regReq.wdata & 16'h1FFF;
			mSt = (mSt & ~statusClear) | eventIn;
		end
		cyc++;
		if (cyc >= 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	initial begin
		repeat (5) @(negedge core_clk);
		reset = 1'b0;
		for (int i = 0; i < 4000; i++) begin
			@(negedge core_clk);
			`CHK(regRdata, mRd)
			`CHK(statusOut, irqmsk_evt_t'(mSt))
			`CHK(irqOut, |(mSt & ~mVec))
			lf = step(lf);
			regReq.writeEn = lf[0];
			regReq.readEn = lf[1];
			// 27h is unmapped and must read zero
			regReq.addr = 8'h24 + 8'(lf[3:2]);
			regReq.wdata = lf[31:16];
			// sparse events so that clears and masks both matter
			eventIn = irqmsk_evt_t'(lf[27:4] & lf[31:8] & lf[26:3]);
			statusClear = irqmsk_evt_t'(lf[30:7] & lf[23:0]);
			reset = (i >= 2000 && i < 2003);
		end
		stop_test();
	end
endmodule // tb_irqmsk_regs
`default_nettype wire
